// ### verilog/qrs_pkg.sv
package qrs_pkg;

  localparam int DATA_W_DEF    = 18;
  localparam int ADDR_W_DEF    = 19;
  localparam int LANE_W        = 9;
  localparam int BURST_WORDS   = 2;

  localparam int MCLK_HZ       = 20_000_000;
  localparam int IMP_PERIOD_US = 20;
  localparam int IMP_PERIOD_CYC = (IMP_PERIOD_US * (MCLK_HZ / 1_000_000));

  localparam int IMP_CODE_W    = 6;
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_RESET = 6'h20;
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_MAX   = 6'h3F;
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_MIN   = 6'h00;

  localparam int CAL_CNT_W     = 16;

  typedef enum logic [1:0] {
    QRS_CAL_POWERUP = 2'b00,
    QRS_CAL_WAIT    = 2'b01,
    QRS_CAL_UPDATE  = 2'b10
  } qrs_cal_state_type;

endpackage

// ### verilog/qrs_array.sv
`timescale 1ns/1ps
module qrs_array #(
  parameter int DATA_W = qrs_pkg::DATA_W_DEF,
  parameter int ADDR_W = qrs_pkg::ADDR_W_DEF,
  parameter int LANES  = qrs_pkg::DATA_W_DEF / qrs_pkg::LANE_W
) (
  input  wire logic              i_wclk_n,
  input  wire logic              i_we,
  input  wire logic [ADDR_W-1:0] i_waddr,
  input  wire logic [DATA_W-1:0] i_wdata0,
  input  wire logic [DATA_W-1:0] i_wdata1,
  input  wire logic [LANES-1:0]  i_lane0_n,
  input  wire logic [LANES-1:0]  i_lane1_n,
  input  wire logic [ADDR_W-1:0] i_raddr,
  output logic      [DATA_W-1:0] o_rdata0,
  output logic      [DATA_W-1:0] o_rdata1
);

  localparam int LW = DATA_W / LANES;

  logic [DATA_W-1:0] mem [0:(2**(ADDR_W+1))-1];

  // both burst words land on the falling link edge that carries the second word
  always_ff @(negedge i_wclk_n) begin
    if (i_we) begin
      for (int l = 0; l < LANES; l++) begin
        if (!i_lane0_n[l]) begin
          mem[{i_waddr, 1'b0}][l*LW +: LW] <= i_wdata0[l*LW +: LW];
        end
        if (!i_lane1_n[l]) begin
          mem[{i_waddr, 1'b1}][l*LW +: LW] <= i_wdata1[l*LW +: LW];
        end
      end
    end
  end

  assign o_rdata0 = mem[{i_raddr, 1'b0}];
  assign o_rdata1 = mem[{i_raddr, 1'b1}];

endmodule

// ### verilog/qrs_impcal.sv
`timescale 1ns/1ps
module qrs_impcal #(
  parameter int PERIOD_CYC = qrs_pkg::IMP_PERIOD_CYC
) (
  input  wire logic                            i_clk,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_cmp_high,
  output logic      [qrs_pkg::IMP_CODE_W-1:0] o_code,
  output logic                                 o_cal,
  output logic                                 o_ready
);

  qrs_pkg::qrs_cal_state_type state;
  logic [qrs_pkg::CAL_CNT_W-1:0] cnt;
  logic                          cmp_meta;
  logic                          cmp_sync;

  always_ff @(posedge i_clk) begin
    cmp_meta <= i_cmp_high;
    cmp_sync <= cmp_meta;
  end

  // first update one period after reset (the POWERUP cycle takes the place of the UPDATE cycle), then one every period
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state   <= qrs_pkg::QRS_CAL_POWERUP;
      cnt     <= '0;
      o_cal   <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      o_cal <= 1'b0;
      case (state)
        qrs_pkg::QRS_CAL_POWERUP: begin
          cnt   <= '0;
          state <= qrs_pkg::QRS_CAL_WAIT;
        end
        qrs_pkg::QRS_CAL_WAIT: begin
          if (cnt == qrs_pkg::CAL_CNT_W'(PERIOD_CYC - 2)) begin
            state <= qrs_pkg::QRS_CAL_UPDATE;
          end
          cnt <= cnt + 1'b1;
        end
        qrs_pkg::QRS_CAL_UPDATE: begin
          o_cal   <= 1'b1;
          o_ready <= 1'b1;
          cnt     <= '0;
          state   <= qrs_pkg::QRS_CAL_WAIT;
        end
        default: begin
          state <= qrs_pkg::QRS_CAL_POWERUP;
        end
      endcase
    end
  end

  // one step per update; comparator high means drive is too strong
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_code <= qrs_pkg::IMP_CODE_RESET;
    end else if (state == qrs_pkg::QRS_CAL_UPDATE) begin
      if (cmp_sync && o_code != qrs_pkg::IMP_CODE_MIN) begin
        o_code <= o_code - 1'b1;
      end else if (!cmp_sync && o_code != qrs_pkg::IMP_CODE_MAX) begin
        o_code <= o_code + 1'b1;
      end
    end
  end

endmodule

// ### verilog/qrs_top.sv
`timescale 1ns/1ps
module qrs_top #(
  parameter int DATA_W     = qrs_pkg::DATA_W_DEF,
  parameter int ADDR_W     = qrs_pkg::ADDR_W_DEF,
  parameter int LANES      = DATA_W / qrs_pkg::LANE_W,
  parameter int IMP_PERIOD = qrs_pkg::IMP_PERIOD_CYC
) (
  input  wire logic                            I_MCLK,
  input  wire logic                            I_RST_N,
  input  wire logic                            I_LINK_CLK,
  input  wire logic                            I_RD_SEL_N,
  input  wire logic                            I_WR_SEL_N,
  input  wire logic [ADDR_W-1:0]               I_ADDR,
  input  wire logic [DATA_W-1:0]               I_WRITE_DATA_IN,
  input  wire logic [LANES-1:0]                I_BYTE_LANE_ENABLE_N,
  input  wire logic                            I_OUT_CLK,
  input  wire logic                            I_OUT_CLK_N,
  input  wire logic                            I_PLL_BYPASS_N,
  input  wire logic                            I_IMPEDANCE_REF_HIGH,
  output logic      [DATA_W-1:0]               O_READ_DATA_OUT,
  output logic                                 O_READ_DATA_OE,
  output logic                                 O_ECHO_STROBE_POS,
  output logic                                 O_ECHO_STROBE_NEG,
  output logic                                 O_OUT_REF_INPUT_CLK,
  output logic                                 O_PLL_BYPASSED,
  output logic      [qrs_pkg::IMP_CODE_W-1:0] O_IMP_CODE,
  output logic                                 O_IMP_CAL,
  output logic                                 O_IMP_READY
);

  // link edges: rising I_LINK_CLK is input_strobe_pos, falling is input_strobe_neg
  logic              rst_core;
  logic              rst_meta;
  logic              rst_link;
  logic              rd_req;
  logic [ADDR_W-1:0] rd_addr;
  logic              rd_valid;
  logic [DATA_W-1:0] rd_hold0;
  logic [DATA_W-1:0] rd_hold1;
  logic [DATA_W-1:0] q_neg;
  logic [DATA_W-1:0] q_pos;
  logic              oe_neg;
  logic              oe_pos;
  logic              wr_pend;
  logic [DATA_W-1:0] wr_word0;
  logic [LANES-1:0]  wr_lane0_n;
  logic [DATA_W-1:0] arr_q0;
  logic [DATA_W-1:0] arr_q1;
  logic              tog_pos;
  logic              tog_neg;
  logic              oc_meta;
  logic              oc_sync;
  logic              ocn_meta;
  logic              ocn_sync;
  logic              byp_meta;
  logic              byp_sync;

  initial begin
    if (DATA_W != 9 && DATA_W != 18 && DATA_W != 36) begin
      $error("unsupported data width");
    end
  end

  // core side: registered reset feeds the link-side synchroniser
  always_ff @(posedge I_MCLK) begin
    rst_core <= I_RST_N;
  end

  always_ff @(posedge I_LINK_CLK) begin
    rst_meta <= rst_core;
    rst_link <= rst_meta;
  end

  // bypass only loosens timing; the protocol itself is unchanged
  always_ff @(posedge I_MCLK) begin
    byp_meta <= I_PLL_BYPASS_N;
    byp_sync <= byp_meta;
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_PLL_BYPASSED <= 1'b0;
    end else begin
      O_PLL_BYPASSED <= !byp_sync;
    end
  end

  qrs_impcal #(
    .PERIOD_CYC (IMP_PERIOD)
  ) u_impcal (
    .i_clk      (I_MCLK),
    .i_rst_n    (I_RST_N),
    .i_cmp_high (I_IMPEDANCE_REF_HIGH),
    .o_code     (O_IMP_CODE),
    .o_cal      (O_IMP_CAL),
    .o_ready    (O_IMP_READY)
  );

  // read request and address taken on the rising link edge
  always_ff @(posedge I_LINK_CLK) begin
    if (!rst_link) begin
      rd_req  <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_req <= !I_RD_SEL_N;
      if (!I_RD_SEL_N) begin
        rd_addr <= I_ADDR;
      end
    end
  end

  // first write word and its lanes ride the rising edge
  always_ff @(posedge I_LINK_CLK) begin
    if (!rst_link) begin
      wr_pend    <= 1'b0;
      wr_word0   <= '0;
      wr_lane0_n <= '1;
    end else begin
      wr_pend <= !I_WR_SEL_N;
      if (!I_WR_SEL_N) begin
        wr_word0   <= I_WRITE_DATA_IN;
        wr_lane0_n <= I_BYTE_LANE_ENABLE_N;
      end
    end
  end

  // write address, second word and lanes go straight in on the falling edge
  qrs_array #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W),
    .LANES  (LANES)
  ) u_array (
    .i_wclk_n  (I_LINK_CLK),
    .i_we      (wr_pend && rst_link),
    .i_waddr   (I_ADDR),
    .i_wdata0  (wr_word0),
    .i_wdata1  (I_WRITE_DATA_IN),
    .i_lane0_n (wr_lane0_n),
    .i_lane1_n (I_BYTE_LANE_ENABLE_N),
    .i_raddr   (rd_addr),
    .o_rdata0  (arr_q0),
    .o_rdata1  (arr_q1)
  );

  // array fetched one rising edge after the request
  always_ff @(posedge I_LINK_CLK) begin
    if (!rst_link) begin
      rd_valid <= 1'b0;
      rd_hold0 <= '0;
      rd_hold1 <= '0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        rd_hold0 <= arr_q0;
        rd_hold1 <= arr_q1;
      end
    end
  end

  // first word on the falling edge of cycle t+1
  always_ff @(negedge I_LINK_CLK) begin
    if (!rst_link) begin
      q_neg  <= '0;
      oe_neg <= 1'b0;
    end else begin
      oe_neg <= rd_valid;
      if (rd_valid) begin
        q_neg <= rd_hold0;
      end
    end
  end

  // second word on the rising edge of cycle t+2
  always_ff @(posedge I_LINK_CLK) begin
    if (!rst_link) begin
      q_pos  <= '0;
      oe_pos <= 1'b0;
    end else begin
      oe_pos <= rd_valid;
      if (rd_valid) begin
        q_pos <= rd_hold1;
      end
    end
  end

  // double-rate output mux; each half cycle shows the flop launched at its edge
  assign O_READ_DATA_OUT = I_LINK_CLK ? q_pos : q_neg;
  assign O_READ_DATA_OE  = I_LINK_CLK ? oe_pos : oe_neg;

  // echo clocks free-run from the launch edges, so they stop with the clock
  always_ff @(posedge I_LINK_CLK) begin
    if (!rst_link) begin
      tog_pos <= 1'b0;
    end else begin
      tog_pos <= !tog_pos;
    end
  end

  always_ff @(negedge I_LINK_CLK) begin
    if (!rst_link) begin
      tog_neg <= 1'b0;
    end else begin
      tog_neg <= tog_pos;
    end
  end

  assign O_ECHO_STROBE_POS = tog_pos ^ tog_neg;
  assign O_ECHO_STROBE_NEG = !(tog_pos ^ tog_neg);

  // output clock pair is only watched for the held-high selection
  always_ff @(posedge I_LINK_CLK) begin
    oc_meta  <= I_OUT_CLK;
    oc_sync  <= oc_meta;
    ocn_meta <= I_OUT_CLK_N;
    ocn_sync <= ocn_meta;
  end

  always_ff @(posedge I_LINK_CLK) begin
    if (!rst_link) begin
      O_OUT_REF_INPUT_CLK <= 1'b0;
    end else begin
      O_OUT_REF_INPUT_CLK <= oc_sync && ocn_sync;
    end
  end

endmodule

// ### testbench/qrs_top_chk.sv
`timescale 1ns/1ps
module qrs_top_chk (
  input wire logic                           I_MCLK,
  input wire logic                           I_RST_N,
  input wire logic                           I_LINK_CLK,
  input wire logic                           I_RD_SEL_N,
  input wire logic                           I_PLL_BYPASS_N,
  input wire logic                           O_READ_DATA_OE,
  input wire logic                           O_ECHO_STROBE_POS,
  input wire logic                           O_ECHO_STROBE_NEG,
  input wire logic                           O_PLL_BYPASSED,
  input wire logic [qrs_pkg::IMP_CODE_W-1:0] O_IMP_CODE,
  input wire logic                           O_IMP_CAL
);
  // sampled at the rising link edge, oe shows the word0 half of the cycle before
  a_read_oe: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
    !I_RD_SEL_N |-> ##2 O_READ_DATA_OE) else $error("read left bus floating");
  a_nop_float: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
    I_RD_SEL_N |-> ##2 !O_READ_DATA_OE) else $error("bus driven without read");
  // echo lives on the link clock; the link reset trails the core reset by a few edges
  a_echo_pair: assert property (@(negedge I_LINK_CLK) disable iff (!I_RST_N)
    $past(I_RST_N, 4) |-> O_ECHO_STROBE_POS && !O_ECHO_STROBE_NEG)
    else $error("echo pair not high with clock");
  a_cal_period: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    O_IMP_CAL |=> !O_IMP_CAL [*6] ##[1:3] O_IMP_CAL) else $error("bad cal period");
  a_cal_first: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    $rose(I_RST_N) |-> ##[4:16] O_IMP_CAL) else $error("no first cal");
  a_code_step: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    $changed(O_IMP_CODE) |-> 6'(O_IMP_CODE - $past(O_IMP_CODE)) inside {6'h01, 6'h3F})
    else $error("code jumped");
  a_byp_set: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    $fell(I_PLL_BYPASS_N) |-> ##[1:5] O_PLL_BYPASSED) else $error("bypass not seen");
  a_byp_clr: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    $rose(I_PLL_BYPASS_N) |-> ##[1:5] !O_PLL_BYPASSED) else $error("bypass stuck");
  c_read: cover property (@(posedge I_LINK_CLK) !I_RD_SEL_N ##2 O_READ_DATA_OE);
  c_cal: cover property (@(posedge I_MCLK) O_IMP_CAL);
  c_byp: cover property (@(posedge I_MCLK) O_PLL_BYPASSED);
endmodule

// ### testbench/qrs_host.sv
`timescale 1ns/1ps
module qrs_host (
  output logic        o_link_clk,
  output logic        o_rd_sel_n,
  output logic        o_wr_sel_n,
  output logic [18:0] o_addr,
  output logic [17:0] o_wdata,
  output logic [1:0]  o_lane_n,
  output logic        o_out_clk,
  output logic        o_out_clk_n
);
  logic oclk_run;
  initial begin
    o_link_clk = 1'h0;
    o_rd_sel_n = 1'h1;
    o_wr_sel_n = 1'h1;
    o_addr = 19'h0_0000;
    o_wdata = 18'h0_0000;
    o_lane_n = 2'h3;
    oclk_run = 1'h0;
  end
  always #62.5 o_link_clk = ~o_link_clk;
  // held high selects the input clocks as launch reference
  assign o_out_clk = oclk_run ? o_link_clk : 1'h1;
  assign o_out_clk_n = oclk_run ? ~o_link_clk : 1'h1;
  // entered just after a falling link edge, so calls run back to back
  task automatic xfer(input logic rd, input logic wr, input logic [18:0] ra,
    input logic [18:0] wa, input logic [17:0] w0, input logic [17:0] w1,
    input logic [1:0] b0, input logic [1:0] b1);
    o_rd_sel_n = rd;
    o_wr_sel_n = wr;
    o_addr = ra;
    o_wdata = w0;
    o_lane_n = b0;
    @(posedge o_link_clk);
    #20;
    o_rd_sel_n = 1'h1;
    o_wr_sel_n = 1'h1;
    o_addr = wa;
    o_wdata = w1;
    o_lane_n = b1;
    @(negedge o_link_clk);
    #20;
  endtask
endmodule

// ### testbench/qrs_top_test.sv
`timescale 1ns/1ps
module qrs_top_test;
  localparam logic [18:0] A = 19'h0_0005;
  localparam logic [18:0] B = 19'h0_0006;
  logic        mclk, rst_n, byp_n, zq_hi;
  wire logic   lclk, rd_n, wr_n, oc, oc_n;
  wire logic [18:0] addr;
  wire logic [17:0] wd;
  wire logic [1:0]  bw;
  logic [17:0] q;
  logic        oe, ep, en, oref, byp, cal, rdy;
  logic [5:0]  code;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  qrs_host host_u (.o_link_clk(lclk), .o_rd_sel_n(rd_n), .o_wr_sel_n(wr_n), .o_addr(addr),
    .o_wdata(wd), .o_lane_n(bw), .o_out_clk(oc), .o_out_clk_n(oc_n));
  qrs_top #(.IMP_PERIOD(8)) dut_u (.I_MCLK(mclk), .I_RST_N(rst_n), .I_LINK_CLK(lclk),
    .I_RD_SEL_N(rd_n), .I_WR_SEL_N(wr_n), .I_ADDR(addr), .I_WRITE_DATA_IN(wd),
    .I_BYTE_LANE_ENABLE_N(bw), .I_OUT_CLK(oc), .I_OUT_CLK_N(oc_n), .I_PLL_BYPASS_N(byp_n),
    .I_IMPEDANCE_REF_HIGH(zq_hi), .O_READ_DATA_OUT(q), .O_READ_DATA_OE(oe),
    .O_ECHO_STROBE_POS(ep), .O_ECHO_STROBE_NEG(en), .O_OUT_REF_INPUT_CLK(oref),
    .O_PLL_BYPASSED(byp), .O_IMP_CODE(code), .O_IMP_CAL(cal), .O_IMP_READY(rdy));
  always #25 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // words of n back-to-back reads, the first requested at the next rising link edge
  task automatic expect_rd(input int n, input logic [17:0] e [4]);
    @(posedge lclk);
    @(posedge lclk);
    for (int i = 0; i < n; i++) begin
      @(negedge lclk);
      #20;
      check(oe, 1'h1);
      check(q, e[2*i]);
      @(posedge lclk);
      #20;
      check(q, e[2*i+1]);
    end
    @(negedge lclk);
    #20;
    check(oe, 1'h0);
  endtask
  task automatic rd_chk(input logic [18:0] ra, input logic [17:0] e [4]);
    fork
      host_u.xfer(1'h0, 1'h1, ra, ra, ~e[0], ~e[1], 2'h3, 2'h3);
      expect_rd(1, e);
    join
  endtask
  task automatic t_lanes();
    host_u.xfer(1'h1, 1'h0, A, A, 18'h1_2345, 18'h2_6789, 2'h0, 2'h0);
    rd_chk(A, '{18'h1_2345, 18'h2_6789, 18'h0_0000, 18'h0_0000});
    // only the low lane of word0 and the high lane of word1 are enabled
    host_u.xfer(1'h1, 1'h0, A, A, 18'h3_FFFF, 18'h0_0000, 2'h2, 2'h1);
    rd_chk(A, '{18'h1_23FF, 18'h0_0189, 18'h0_0000, 18'h0_0000});
    host_u.xfer(1'h1, 1'h1, A, A, 18'h0_0000, 18'h0_0000, 2'h0, 2'h0);
    rd_chk(A, '{18'h1_23FF, 18'h0_0189, 18'h0_0000, 18'h0_0000});
  endtask
  task automatic t_rw_same();
    fork
      begin
        host_u.xfer(1'h0, 1'h0, A, B, 18'h0_ABCD, 18'h3_0F0F, 2'h0, 2'h0);
        host_u.xfer(1'h0, 1'h1, B, B, 18'h0_0000, 18'h0_0000, 2'h3, 2'h3);
      end
      expect_rd(2, '{18'h1_23FF, 18'h0_0189, 18'h0_ABCD, 18'h3_0F0F});
    join
  endtask
  task automatic t_misc();
    int n;
    logic [5:0] c;
    n = 0;
    check(oref, 1'h1);
    host_u.oclk_run = 1'h1;
    for (int i = 0; i < 40 && oref !== 1'h0; i++) @(negedge mclk);
    check(oref, 1'h0);
    for (int i = 0; i < 20; i++) begin
      @(negedge mclk);
      n += int'(ep);
      check(en, !ep);
    end
    check(n > 4 && n < 16, 1'h1);
    byp_n = 1'h0;
    repeat (6) @(negedge mclk);
    check(byp, 1'h1);
    byp_n = 1'h1;
    repeat (6) @(negedge mclk);
    check(byp, 1'h0);
    n = 0;
    zq_hi = 1'h1;
    // let the comparator level pass its synchroniser before the count starts
    repeat (3) @(negedge mclk);
    c = code;
    repeat (40) begin
      @(negedge mclk);
      n += int'(cal);
    end
    check(n, 5);
    check(rdy, 1'h1);
    check(code, c - 6'h05);
  endtask
  initial begin
    mclk = 1'h0;
    rst_n = 1'h0;
    byp_n = 1'h1;
    zq_hi = 1'h0;
    repeat (12) @(negedge mclk);
    check(oe, 1'h0);
    check(code, 6'h20);
    check({ep, en}, 2'h1);
    rst_n = 1'h1;
    repeat (6) @(posedge lclk);
    @(negedge lclk);
    #20;
    t_lanes();
    t_rw_same();
    @(negedge mclk);
    t_misc();
    finish_test();
  end
endmodule
bind qrs_top qrs_top_chk chk_u (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_LINK_CLK(I_LINK_CLK),
  .I_RD_SEL_N(I_RD_SEL_N), .I_PLL_BYPASS_N(I_PLL_BYPASS_N), .O_READ_DATA_OE(O_READ_DATA_OE),
  .O_ECHO_STROBE_POS(O_ECHO_STROBE_POS), .O_ECHO_STROBE_NEG(O_ECHO_STROBE_NEG),
  .O_PLL_BYPASSED(O_PLL_BYPASSED), .O_IMP_CODE(O_IMP_CODE), .O_IMP_CAL(O_IMP_CAL));
